// ==== dsa_chk.sv ====
// Checker for screen halves, memory phase and shift clock timing
`timescale 1ns/1ps
`default_nettype none
module dsa_chk (
  // Clock and reset
  input wire logic       DOT_CLK,
  input wire logic       RSTN,
  // Mode pins
  input wire logic       DISPLAY_TYPE_SELECT,
  input wire logic       RESOLUTION_SELECT,
  input wire logic       FONT_WIDTH_SEL_LO,
  input wire logic       FONT_WIDTH_SEL_HI,
  input wire logic [1:0] DATA_WIDTH_SEL,
  // Display outputs
  input wire logic [4:0] SCAN_LINE_ADDRESS,
  input wire logic       SCREEN_HALF_SELECT,
  input wire logic       MEM_PHASE,
  input wire logic       LCD_SHIFT_CLOCK
);
  logic lcd8;
  logic lane1;
  logic lane4;
  // LCD, high resolution, eight dot font, by lane count
  assign lcd8  = DISPLAY_TYPE_SELECT && RESOLUTION_SELECT && FONT_WIDTH_SEL_LO && FONT_WIDTH_SEL_HI;
  assign lane1 = lcd8 && (DATA_WIDTH_SEL == dsa_pkg::LANES_1);
  assign lane4 = lcd8 && DATA_WIDTH_SEL[1];
  default clocking cb @(posedge DOT_CLK); endclocking
  default disable iff (!RSTN);
  // Tails of pulses whose length is fixed
  sequence half_tail; SCREEN_HALF_SELECT[*7] ##1 !SCREEN_HALF_SELECT; endsequence
  sequence phase_tail; MEM_PHASE[*3] ##1 !MEM_PHASE; endsequence
  sequence sck_tail; LCD_SHIFT_CLOCK[*3] ##1 !LCD_SHIFT_CLOCK; endsequence
  // LCD mode with font and resolution pins unchanged for eight dots
  sequence lcd_steady;
    (DISPLAY_TYPE_SELECT && $stable({RESOLUTION_SELECT, FONT_WIDTH_SEL_LO, FONT_WIDTH_SEL_HI}))[*8];
  endsequence
  chk_crt_half_low: assert property ((!DISPLAY_TYPE_SELECT)[*4] |-> !SCREEN_HALF_SELECT)
    else $error("half select high in CRT mode");
  chk_crt_sck_idle: assert property ((!DISPLAY_TYPE_SELECT)[*4] |-> !LCD_SHIFT_CLOCK)
    else $error("shift clock running in CRT mode");
  chk_scan_line_hold: assert property ($rose(SCREEN_HALF_SELECT) |-> $stable(SCAN_LINE_ADDRESS))
    else $error("scan line changed between halves");
  chk_phase_at_half: assert property (lcd_steady ##0 $changed(SCREEN_HALF_SELECT) |-> !MEM_PHASE)
    else $error("memory phase high at half edge");
  chk_half_len_eight: assert property (lcd8[*8] ##0 $rose(SCREEN_HALF_SELECT) |-> ##1 half_tail)
    else $error("half select length wrong");
  chk_phase_len_four: assert property (lcd8[*8] ##0 $rose(MEM_PHASE) |-> ##1 phase_tail)
    else $error("memory phase length wrong");
  chk_sck_one_lane: assert property (lane1[*8] ##0 $rose(LCD_SHIFT_CLOCK) |=> !LCD_SHIFT_CLOCK)
    else $error("shift clock not half dot rate");
  chk_sck_four_lane: assert property (lane4[*8] ##0 $rose(LCD_SHIFT_CLOCK) |-> ##1 sck_tail)
    else $error("shift clock not eighth dot rate");
endmodule : dsa_chk
bind dsa_top dsa_chk dsa_chk_i (.DOT_CLK(DOT_CLK), .RSTN(RSTN), .DISPLAY_TYPE_SELECT(DISPLAY_TYPE_SELECT),
  .RESOLUTION_SELECT(RESOLUTION_SELECT), .FONT_WIDTH_SEL_LO(FONT_WIDTH_SEL_LO), .FONT_WIDTH_SEL_HI(FONT_WIDTH_SEL_HI),
  .DATA_WIDTH_SEL(DATA_WIDTH_SEL), .SCAN_LINE_ADDRESS(SCAN_LINE_ADDRESS), .SCREEN_HALF_SELECT(SCREEN_HALF_SELECT),
  .MEM_PHASE(MEM_PHASE), .LCD_SHIFT_CLOCK(LCD_SHIFT_CLOCK));
`default_nettype wire

// ==== dsa_mem_model.sv ====
// Display refresh memory answering each address with a nonzero byte
`timescale 1ns/1ps
`default_nettype none
module dsa_mem_model (
  // Clock
  input  wire logic        clk,
  // Refresh side
  input  wire logic [15:0] addr,
  output logic      [7:0]  data
);
  // Read latched on the dot clock, so no skew is needed
  always_ff @(posedge clk) begin
    data <= {addr[3:0], ~addr[3:0]}; // No host access to collide with
  end
endmodule : dsa_mem_model
`default_nettype wire

// ==== dsa_pkg.sv ====
// Constants, register indices and field positions for the dual screen display addressing block
//
// Contract
// - Lower-screen address is the 16-bit offset pair added to the upper-screen counter.
// - Shift-clock start and end positions select the character window sent to the panel.
// - Characters outside display start and end positions are blanked on every line.
// - First displayed row starts at the start address pair; changing it scrolls vertically.
// - Font width inputs pick 5, 6, 7 or 8 dots; only those bits are used.
// - Display type 0 runs the CRT controller only; 1 selects LCD mode.
// - In LCD mode the address counter cycle is twice the CRT cycle.
// - Bit 7 of shift-clock start selects two-screen mode; zero gives one screen.
// - Two-screen mode drives upper address while half select low, lower while high.
// - Scan-line address stays unchanged across both halves of the half select period.
// - Half select period is twice memory phase; phase low first, high second.
// - One-screen mode shows upper address all period; memory phase timing unchanged.
// - Low resolution outputs every dot twice, halving characters per line.
// - At 16 MHz dots, address cycle is 500 ns, or 1000 ns in LCD mode.
// - Shift clock is dot clock over 2, 4 or 8 for 1, 2, 4 bit data; low resolution divides by 4, 8 or 16 instead.
// - Two-screen cursor goes to lower screen when cursor start bit 7 is set.
// - Display enable timing is delayed 0, 1 or 2 characters by skew bits 5:4.
package dsa_pkg;

  // Register file geometry
  localparam int unsigned REG_IDX_W = 5;
  localparam int unsigned REG_COUNT = 24;
  localparam logic [7:0]  REG_RESET = 8'h00;

  // Register indices
  localparam logic [4:0] IDX_HTOTAL      = 5'h00;
  localparam logic [4:0] IDX_HDISP       = 5'h01;
  localparam logic [4:0] IDX_VTOTAL      = 5'h04;
  localparam logic [4:0] IDX_SKEW        = 5'h08;
  localparam logic [4:0] IDX_MAXSCAN     = 5'h09;
  localparam logic [4:0] IDX_CUR_START   = 5'h0a;
  localparam logic [4:0] IDX_CUR_END     = 5'h0b;
  localparam logic [4:0] IDX_START_HI    = 5'h0c;
  localparam logic [4:0] IDX_START_LO    = 5'h0d;
  localparam logic [4:0] IDX_CURSOR_HI   = 5'h0e;
  localparam logic [4:0] IDX_CURSOR_LO   = 5'h0f;
  localparam logic [4:0] IDX_SHIFT_START = 5'h12;
  localparam logic [4:0] IDX_SHIFT_END   = 5'h13;
  localparam logic [4:0] IDX_DISP_START  = 5'h14;
  localparam logic [4:0] IDX_DISP_END    = 5'h15;
  localparam logic [4:0] IDX_LOWER_OFS_HI = 5'h16;
  localparam logic [4:0] IDX_LOWER_OFS_LO = 5'h17;

  // Field positions
  localparam int unsigned SCREENS_BIT       = 7;
  localparam int unsigned CURSOR_SCREEN_BIT = 7;
  localparam int unsigned CUR_MODE_LSB      = 5;
  localparam int unsigned DE_SKEW_LSB       = 4;
  localparam int unsigned CUR_SKEW_LSB      = 6;
  localparam int unsigned SCAN_W            = 5;

  // Cursor mode code that hides the cursor
  localparam logic [1:0] CUR_MODE_HIDDEN = 2'h1;

  // Font width base count of dots
  localparam logic [3:0] FONT_DOTS_BASE = 4'h5;

  // Lane select codes of the data width input
  localparam logic [1:0] LANES_1 = 2'h0;
  localparam logic [1:0] LANES_2 = 2'h1;

  // Bits that pass the pin synchronisers of the dot and host domains
  localparam int unsigned DOT_PIN_W  = 14;
  localparam int unsigned HOST_PIN_W = 12;

  // Registers that the host may read back
  function automatic logic is_readable(input logic [4:0] idx);
    is_readable = (idx >= IDX_START_HI && idx <= IDX_CURSOR_LO) ||
                  (idx >= IDX_SHIFT_START && idx <= IDX_LOWER_OFS_LO);
  endfunction : is_readable

endpackage : dsa_pkg

// ==== dsa_sync.sv ====
// Two flip-flop synchroniser for a bundle of level signals
`timescale 1ns/1ps
`default_nettype none
module dsa_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Destination clock and reset
  input  wire  logic             clk,
  input  wire  logic             rst_n,
  // Levels from another domain
  input  wire  logic [WIDTH-1:0] async_in,
  // Synchronised levels
  output logic       [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : dsa_sync
`default_nettype wire

// ==== dsa_tb.sv ====
// Testbench for the dual screen display addressing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        sys_clk = 0, rstn = 0, dot_clk = 0, host_e = 0, host_cs_n = 1, host_rs = 0, host_rw = 1;
  logic [7:0]  host_d_in = 8'h00, host_d_out, mem_data;
  logic        disp_type = 1, res_sel = 1, font_lo = 1, font_hi = 1, host_d_oe, half, phase, de, cur, sck;
  logic [1:0]  width_sel = 2'h0;
  logic [15:0] addr;
  logic [4:0]  scan;
  logic [3:0]  up_data, lo_data;
  int          mismatches = 0, n_compared = 0;
  // Clocks of unrelated phase
  initial forever #5 sys_clk = ~sys_clk;
  initial begin #3; forever #24 dot_clk = ~dot_clk; end
  dsa_top dsa_top_i (.SYS_CLK(sys_clk), .RSTN(rstn), .DOT_CLK(dot_clk), .HOST_E(host_e), .HOST_CS_N(host_cs_n),
    .HOST_RS(host_rs), .HOST_RW(host_rw), .HOST_D_IN(host_d_in), .HOST_D_OUT(host_d_out), .HOST_D_OE(host_d_oe),
    .DISPLAY_TYPE_SELECT(disp_type), .RESOLUTION_SELECT(res_sel), .FONT_WIDTH_SEL_LO(font_lo),
    .FONT_WIDTH_SEL_HI(font_hi), .DATA_WIDTH_SEL(width_sel), .MEM_DATA(mem_data), .REFRESH_ADDRESS(addr),
    .SCAN_LINE_ADDRESS(scan), .SCREEN_HALF_SELECT(half), .MEM_PHASE(phase), .DISPLAY_ENABLE_TIMING(de),
    .CURSOR_DISPLAY_OUT(cur), .LCD_SHIFT_CLOCK(sck), .LCD_UPPER_DATA(up_data), .LCD_LOWER_DATA(lo_data));
  dsa_mem_model dsa_mem_model_i (.clk(dot_clk), .addr(addr), .data(mem_data));
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic fail_wait;
    mismatches++;
    give_verdict();
  endtask : fail_wait
  // One bus cycle; E held 250 ns, cycles kept over 500 ns apart
  task automatic host_cycle(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge sys_clk); #1;
    {host_cs_n, host_rs, host_rw, host_d_in, host_e} = {1'b0, rs, rw, d, 1'b1};
    repeat (25) @(posedge sys_clk);
    for (n = 0; rw && host_d_oe !== 1'b1; n++) begin
      if (n > 20) fail_wait();
      @(posedge sys_clk);
    end
    q = host_d_out;
    #1 host_e = 1'b0;
    repeat (30) @(posedge sys_clk);
    #1 host_cs_n = 1'b1;
  endtask : host_cycle
  task automatic wr(input logic [4:0] idx, input logic [7:0] v);
    logic [7:0] q;
    host_cycle(1'b0, 1'b0, {3'h0, idx}, q);
    host_cycle(1'b1, 1'b0, v, q);
  endtask : wr
  task automatic rd(input logic [4:0] idx, output logic [7:0] q);
    host_cycle(1'b0, 1'b0, {3'h0, idx}, q);
    host_cycle(1'b1, 1'b1, 8'h00, q);
  endtask : rd
  task automatic dots(input int n);
    repeat (n) @(posedge dot_clk);
    #1;
  endtask : dots
  function automatic logic pick(input int s);
    pick = (s == 0) ? half : (s == 1) ? sck : (s == 2) ? de : cur;
  endfunction : pick
  task automatic wait_for(input int s, input logic v);
    for (int n = 0; pick(s) !== v; n++) begin
      if (n > 2000) fail_wait();
      dots(1);
    end
  endtask : wait_for
  task automatic high_len(input int s, output int len);
    wait_for(s, 1'b0);
    wait_for(s, 1'b1);
    for (len = 0; pick(s) === 1'b1 && len < 200; len++) dots(1);
  endtask : high_len
  task automatic addr_run(output int len);
    logic [15:0] a;
    a = addr;
    for (len = 0; addr === a && len < 200; len++) dots(1);
    a = addr;
    for (len = 0; addr === a && len < 200; len++) dots(1);
  endtask : addr_run
  task automatic t_regs;
    logic [7:0] q;
    rd(dsa_pkg::IDX_LOWER_OFS_HI, q); `CHK(q, dsa_pkg::REG_RESET)
    wr(dsa_pkg::IDX_LOWER_OFS_HI, 8'hff);
    wr(dsa_pkg::IDX_LOWER_OFS_LO, 8'hfc);
    rd(dsa_pkg::IDX_LOWER_OFS_HI, q); `CHK(q, 8'hff)
    rd(dsa_pkg::IDX_LOWER_OFS_LO, q); `CHK(q, 8'hfc)
    rd(dsa_pkg::IDX_HTOTAL, q); `CHK(q, 8'h00)
  endtask : t_regs
  task automatic t_two_screen;
    logic [15:0] up;
    repeat (4) begin
      wait_for(0, 1'b0);
      up = addr;
      wait_for(0, 1'b1);
      `CHK(addr, up + 16'hfffc)
    end
  endtask : t_two_screen
  task automatic t_one_screen;
    logic [15:0] up;
    int len;
    wr(dsa_pkg::IDX_SHIFT_START, 8'h00);
    dots(40);
    wait_for(0, 1'b0);
    up = addr;
    wait_for(0, 1'b1);
    `CHK(addr, up)
    addr_run(len); `CHK(len, 16)
    wr(dsa_pkg::IDX_SHIFT_START, 8'h80);
  endtask : t_one_screen
  task automatic t_crt;
    int len;
    disp_type = 1'b0;
    dots(20);
    addr_run(len); `CHK(len, 8)
    `CHK(half, 1'b0)
    `CHK(sck, 1'b0)
    disp_type = 1'b1;
    dots(20);
  endtask : t_crt
  task automatic t_font;
    int len;
    for (int c = 0; c < 4; c++) begin
      {font_hi, font_lo} = c[1:0];
      dots(20);
      high_len(0, len); `CHK(len, 5 + c)
    end
    res_sel = 1'b0;
    wr(dsa_pkg::IDX_HDISP, 8'h02); // Timing rewritten with the pin
    high_len(0, len); `CHK(len, 16)
    res_sel = 1'b1;
    wr(dsa_pkg::IDX_HDISP, 8'h06);
  endtask : t_font
  task automatic t_sck;
    int len;
    logic [7:0] seen;
    for (int l = 0; l < 3; l++) begin
      width_sel = 2'(l);
      dots(20);
      high_len(1, len); `CHK(len, 1 << l)
    end
    width_sel = 2'h0;
    wr(dsa_pkg::IDX_SHIFT_END, 8'h00);
    dots(40);
    seen = 8'h00;
    repeat (64) begin dots(1); seen += {7'h00, sck}; end
    `CHK(seen, 8'h00)
    wr(dsa_pkg::IDX_SHIFT_END, 8'h06);
  endtask : t_sck
  task automatic t_mask;
    logic [3:0] acc;
    for (int k = 0; k < 2; k++) begin
      wr(dsa_pkg::IDX_DISP_END, k ? 8'h06 : 8'h00);
      dots(40);
      acc = 4'h0;
      repeat (64) begin dots(1); acc |= up_data | lo_data; end
      `CHK(acc != 4'h0, k == 1)
    end
  endtask : t_mask
  task automatic t_scroll;
    int n;
    wr(dsa_pkg::IDX_START_HI, 8'h01);
    wr(dsa_pkg::IDX_START_LO, 8'h20);
    for (n = 0; n < 2000 && !(addr === 16'h0120 && half === 1'b0); n++) dots(1);
    `CHK(n < 2000, 1'b1)
  endtask : t_scroll
  // Display enable rises one column later per skew step; line bases are start plus multiples of six
  task automatic t_skew;
    for (int k = 0; k < 3; k++) begin
      wr(dsa_pkg::IDX_SKEW, 8'(k << 4));
      dots(40);
      wait_for(2, 1'b0);
      wait_for(2, 1'b1);
      `CHK((addr - 16'h0120) % 16'h0006, 16'(k))
    end
  endtask : t_skew
  // Cursor at upper-counter address 0121 shown in the half chosen by the screen bit
  task automatic t_cursor;
    wr(dsa_pkg::IDX_CURSOR_HI, 8'h01);
    wr(dsa_pkg::IDX_CURSOR_LO, 8'h21);
    wr(dsa_pkg::IDX_CUR_END, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(dsa_pkg::IDX_CUR_START, k ? 8'h80 : 8'h00);
      dots(40);
      wait_for(3, 1'b0);
      wait_for(3, 1'b1);
      `CHK(half, k == 1)
      `CHK(addr, k ? 16'h0121 + 16'hfffc : 16'h0121)
    end
  endtask : t_cursor
  // Main sequence; total and max-scan values are counts less one
  initial begin
    logic [4:0] idx [8] = '{5'h00, 5'h01, 5'h04, 5'h09, 5'h12, 5'h13, 5'h14, 5'h15};
    logic [7:0] val [8] = '{8'h07, 8'h06, 8'h01, 8'h01, 8'h80, 8'h06, 8'h00, 8'h06};
    repeat (12) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) wr(idx[i], val[i]);
    t_regs();
    dots(40);
    t_two_screen();
    t_one_screen();
    t_crt();
    t_font();
    t_sck();
    t_mask();
    t_scroll();
    t_skew();
    t_cursor();
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// ==== dsa_top.sv ====
// Refresh addressing, screen halves, scrolling, masking and panel serialising
`timescale 1ns/1ps
`default_nettype none
module dsa_top #(
  parameter int unsigned ADDR_W = 16
) (
  // System clock domain
  input  wire  logic        SYS_CLK,
  input  wire  logic        RSTN,
  // Dot clock domain
  input  wire  logic        DOT_CLK,
  // Host register port
  input  wire  logic        HOST_E,
  input  wire  logic        HOST_CS_N,
  input  wire  logic        HOST_RS,
  input  wire  logic        HOST_RW,
  input  wire  logic [7:0]  HOST_D_IN,
  output logic       [7:0]  HOST_D_OUT,
  output logic              HOST_D_OE,
  // Mode pins
  input  wire  logic        DISPLAY_TYPE_SELECT,
  input  wire  logic        RESOLUTION_SELECT,
  input  wire  logic        FONT_WIDTH_SEL_LO,
  input  wire  logic        FONT_WIDTH_SEL_HI,
  input  wire  logic [1:0]  DATA_WIDTH_SEL,
  // Display memory
  input  wire  logic [7:0]  MEM_DATA,
  output logic [ADDR_W-1:0] REFRESH_ADDRESS,
  output logic       [4:0]  SCAN_LINE_ADDRESS,
  output logic              SCREEN_HALF_SELECT,
  output logic              MEM_PHASE,
  // Timing and panel
  output logic              DISPLAY_ENABLE_TIMING,
  output logic              CURSOR_DISPLAY_OUT,
  output logic              LCD_SHIFT_CLOCK,
  output logic       [3:0]  LCD_UPPER_DATA,
  output logic       [3:0]  LCD_LOWER_DATA
);

  // Refuse widths the address logic cannot serve
  if (ADDR_W != 16) begin : g_bad_width
    $error("dsa_top supports a 16-bit refresh address only");
  end

  // ---------------- Host side, system clock ----------------
  logic [dsa_pkg::HOST_PIN_W-1:0] host_sync;
  logic                           e_s;
  logic                           cs_n_s;
  logic                           rs_s;
  logic                           rw_s;
  logic [7:0]                     d_s;
  logic                           e_prev;
  logic [4:0]                     addr_reg;
  logic [7:0]                     host_regs [dsa_pkg::REG_COUNT];
  logic [4:0]                     wr_addr_hold;
  logic [7:0]                     wr_data_hold;
  logic                           wr_toggle;
  logic                           e_fall;

  dsa_sync #(.WIDTH(dsa_pkg::HOST_PIN_W)) u_host_sync (
    .clk      (SYS_CLK),
    .rst_n    (RSTN),
    .async_in ({HOST_E, HOST_CS_N, HOST_RS, HOST_RW, HOST_D_IN}),
    .sync_out (host_sync)
  );

  assign {e_s, cs_n_s, rs_s, rw_s, d_s} = host_sync;
  assign e_fall = e_prev & ~e_s;

  // Host writes land on the falling edge of E
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      e_prev       <= 1'b0;
      addr_reg     <= 5'h00;
      wr_addr_hold <= 5'h00;
      wr_data_hold <= dsa_pkg::REG_RESET;
      wr_toggle    <= 1'b0;
      for (int i = 0; i < dsa_pkg::REG_COUNT; i++) begin
        host_regs[i] <= dsa_pkg::REG_RESET;
      end
    end else begin
      e_prev <= e_s;
      if (e_fall && !cs_n_s && !rw_s) begin
        if (!rs_s) begin
          addr_reg <= d_s[4:0];
        end else if (addr_reg < 5'(dsa_pkg::REG_COUNT)) begin
          host_regs[addr_reg] <= d_s;
          wr_addr_hold        <= addr_reg;
          wr_data_hold        <= d_s;
          wr_toggle           <= ~wr_toggle;
        end
      end
    end
  end

  // Read data and bus drive, registered
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      HOST_D_OUT <= 8'h00;
      HOST_D_OE  <= 1'b0;
    end else begin
      HOST_D_OE <= e_s & ~cs_n_s & rw_s;
      if (rs_s && addr_reg < 5'(dsa_pkg::REG_COUNT) && dsa_pkg::is_readable(addr_reg)) begin
        HOST_D_OUT <= host_regs[addr_reg];
      end else begin
        HOST_D_OUT <= 8'h00;
      end
    end
  end

  // ---------------- Dot clock domain ----------------
  logic [dsa_pkg::DOT_PIN_W-1:0] dot_pins;
  logic [7:0]  s_data;
  logic [1:0]  s_width;
  logic        s_fhi;
  logic        s_flo;
  logic        s_res;
  logic        lcd;
  logic        toggle_s;
  logic        toggle_prev;
  logic [7:0]  cfg [dsa_pkg::REG_COUNT];

  dsa_sync #(.WIDTH(dsa_pkg::DOT_PIN_W)) u_dot_sync (
    .clk      (DOT_CLK),
    .rst_n    (RSTN),
    .async_in ({MEM_DATA, DATA_WIDTH_SEL, FONT_WIDTH_SEL_HI, FONT_WIDTH_SEL_LO,
                RESOLUTION_SELECT, DISPLAY_TYPE_SELECT}),
    .sync_out (dot_pins)
  );

  dsa_sync #(.WIDTH(1)) u_wr_sync (
    .clk      (DOT_CLK),
    .rst_n    (RSTN),
    .async_in (wr_toggle),
    .sync_out (toggle_s)
  );

  assign {s_data, s_width, s_fhi, s_flo, s_res, lcd} = dot_pins;

  // Register copy; hold bus is stable long before the toggle arrives
  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      toggle_prev <= 1'b0;
      for (int i = 0; i < dsa_pkg::REG_COUNT; i++) begin
        cfg[i] <= dsa_pkg::REG_RESET;
      end
    end else begin
      toggle_prev <= toggle_s;
      if (toggle_s != toggle_prev) begin
        cfg[wr_addr_hold] <= wr_data_hold;
      end
    end
  end

  // Decoded settings
  logic        two_screen;
  logic        lowres;
  logic [3:0]  font_w;
  logic [4:0]  char_len;
  logic [5:0]  cyc_len;
  logic [1:0]  pix_sh;
  logic [2:0]  lane_sh;
  logic [4:0]  sc_div;
  logic [15:0] start_addr;
  logic [15:0] cursor_addr;
  logic [15:0] lower_ofs;

  assign two_screen  = lcd & cfg[dsa_pkg::IDX_SHIFT_START][dsa_pkg::SCREENS_BIT];
  assign lowres      = ~s_res;
  assign font_w      = dsa_pkg::FONT_DOTS_BASE + {2'b00, s_fhi, s_flo};
  assign char_len    = lowres ? {font_w, 1'b0} : {1'b0, font_w};
  assign cyc_len     = lcd ? {char_len, 1'b0} : {1'b0, char_len};
  assign pix_sh      = {1'b0, lcd} + {1'b0, lowres};
  assign lane_sh     = (s_width == dsa_pkg::LANES_1) ? 3'h0 :
                       (s_width == dsa_pkg::LANES_2) ? 3'h1 : 3'h2;
  assign sc_div      = 5'h01 << ({1'b0, pix_sh} + lane_sh);
  assign start_addr  = {cfg[dsa_pkg::IDX_START_HI], cfg[dsa_pkg::IDX_START_LO]};
  assign cursor_addr = {cfg[dsa_pkg::IDX_CURSOR_HI], cfg[dsa_pkg::IDX_CURSOR_LO]};
  assign lower_ofs   = {cfg[dsa_pkg::IDX_LOWER_OFS_HI], cfg[dsa_pkg::IDX_LOWER_OFS_LO]};

  // Position within one address cycle
  logic [5:0] dot_cnt;
  logic       end_cycle;
  logic       half_hi;
  logic [5:0] pos_in_half;
  logic       phase_hi;

  assign end_cycle   = (dot_cnt == cyc_len - 6'h01);
  assign half_hi     = lcd & (dot_cnt >= {1'b0, char_len});
  assign pos_in_half = half_hi ? dot_cnt - {1'b0, char_len} : dot_cnt;
  assign phase_hi    = (pos_in_half >= {2'b00, char_len[4:1]});

  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dot_cnt <= 6'h00;
    end else if (end_cycle || dot_cnt >= cyc_len) begin
      dot_cnt <= 6'h00;
    end else begin
      dot_cnt <= dot_cnt + 6'h01;
    end
  end

  // Raster counters and upper-screen address counter
  logic [7:0]  col;
  logic [4:0]  scan;
  logic [7:0]  row;
  logic [15:0] upper_ctr;
  logic [15:0] line_base;
  logic [15:0] next_base;

  assign next_base = line_base + {8'h00, cfg[dsa_pkg::IDX_HDISP]};

  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      col       <= 8'h00;
      scan      <= 5'h00;
      row       <= 8'h00;
      upper_ctr <= 16'h0000;
      line_base <= 16'h0000;
    end else if (end_cycle) begin
      if (col >= cfg[dsa_pkg::IDX_HTOTAL]) begin
        col <= 8'h00;
        if (scan >= cfg[dsa_pkg::IDX_MAXSCAN][4:0]) begin
          scan <= 5'h00;
          if (row >= cfg[dsa_pkg::IDX_VTOTAL]) begin
            row       <= 8'h00;
            line_base <= start_addr;
            upper_ctr <= start_addr;
          end else begin
            row       <= row + 8'h01;
            line_base <= next_base;
            upper_ctr <= next_base;
          end
        end else begin
          scan      <= scan + 5'h01;
          upper_ctr <= line_base;
        end
      end else begin
        col       <= col + 8'h01;
        upper_ctr <= upper_ctr + 16'h0001;
      end
    end
  end

  // Memory side outputs; scan line never changes between halves
  logic [15:0] lower_addr;
  assign lower_addr = upper_ctr + lower_ofs;

  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REFRESH_ADDRESS    <= '0;
      SCAN_LINE_ADDRESS  <= 5'h00;
      SCREEN_HALF_SELECT <= 1'b0;
      MEM_PHASE          <= 1'b0;
    end else begin
      REFRESH_ADDRESS    <= (two_screen && half_hi) ? lower_addr : upper_ctr;
      SCAN_LINE_ADDRESS  <= scan;
      SCREEN_HALF_SELECT <= half_hi;
      MEM_PHASE          <= phase_hi;
    end
  end

  // Display enable and cursor, delayed by whole address cycles
  logic       de_raw;
  logic       cur_raw;
  logic [1:0] de_pipe;
  logic [1:0] cur_pipe;
  logic [1:0] de_skew;
  logic [1:0] cur_skew;
  logic       de_sel;
  logic       cur_sel;
  logic       cur_half_ok;

  assign de_raw   = (col < cfg[dsa_pkg::IDX_HDISP]);
  assign cur_raw  = de_raw && (upper_ctr == cursor_addr) &&
                    (scan >= cfg[dsa_pkg::IDX_CUR_START][4:0]) &&
                    (scan <= cfg[dsa_pkg::IDX_CUR_END][4:0]) &&
                    (cfg[dsa_pkg::IDX_CUR_START][dsa_pkg::CUR_MODE_LSB +: 2] != dsa_pkg::CUR_MODE_HIDDEN);
  assign de_skew  = cfg[dsa_pkg::IDX_SKEW][dsa_pkg::DE_SKEW_LSB +: 2];
  assign cur_skew = cfg[dsa_pkg::IDX_SKEW][dsa_pkg::CUR_SKEW_LSB +: 2];
  assign de_sel   = (de_skew == 2'h0) ? de_raw : (de_skew == 2'h1) ? de_pipe[0] : de_pipe[1];
  assign cur_sel  = (cur_skew == 2'h0) ? cur_raw : (cur_skew == 2'h1) ? cur_pipe[0] : cur_pipe[1];
  assign cur_half_ok = !two_screen ||
                       (half_hi == cfg[dsa_pkg::IDX_CUR_START][dsa_pkg::CURSOR_SCREEN_BIT]);

  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      de_pipe  <= 2'h0;
      cur_pipe <= 2'h0;
    end else if (end_cycle) begin
      de_pipe  <= {de_pipe[0], de_raw};
      cur_pipe <= {cur_pipe[0], cur_raw};
    end
  end

  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DISPLAY_ENABLE_TIMING <= 1'b0;
      CURSOR_DISPLAY_OUT    <= 1'b0;
    end else begin
      DISPLAY_ENABLE_TIMING <= de_sel;
      CURSOR_DISPLAY_OUT    <= cur_sel & cur_half_ok;
    end
  end

  // Character data latches; each byte is shown during the following cycle
  logic [7:0] up_latch;
  logic [7:0] ser_up;
  logic [7:0] ser_lo;
  logic [7:0] ser_col;

  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      up_latch <= 8'h00;
      ser_up   <= 8'h00;
      ser_lo   <= 8'h00;
      ser_col  <= 8'h00;
    end else begin
      if (lcd && dot_cnt == {1'b0, char_len} - 6'h01) begin
        up_latch <= s_data;
      end
      if (end_cycle) begin
        ser_up  <= lcd ? up_latch : s_data;
        ser_lo  <= two_screen ? s_data : 8'h00;
        ser_col <= col;
      end
    end
  end

  // Pixel selection, window and mask
  logic [5:0] pix_idx;
  logic       pix_step;
  logic       mask_win;
  logic       shift_win;
  logic       pix_up;
  logic       pix_lo;
  logic [3:0] up_sr;
  logic [3:0] lo_sr;
  logic [4:0] sc_cnt;
  logic [3:0] lane_mask;

  assign pix_idx   = dot_cnt >> pix_sh;
  assign pix_step  = ((dot_cnt & ((6'h01 << pix_sh) - 6'h01)) == 6'h00);
  assign mask_win  = (ser_col >= cfg[dsa_pkg::IDX_DISP_START]) &&
                     (ser_col <  cfg[dsa_pkg::IDX_DISP_END]);
  assign shift_win = lcd && (ser_col >= {1'b0, cfg[dsa_pkg::IDX_SHIFT_START][6:0]}) &&
                     (ser_col < cfg[dsa_pkg::IDX_SHIFT_END]);
  assign pix_up    = mask_win & ser_up[3'h7 - pix_idx[2:0]];
  assign pix_lo    = mask_win & ser_lo[3'h7 - pix_idx[2:0]];
  assign lane_mask = (lane_sh == 3'h0) ? 4'h1 : (lane_sh == 3'h1) ? 4'h3 : 4'hf;

  // Pixel shifters feeding the panel lanes
  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      up_sr <= 4'h0;
      lo_sr <= 4'h0;
    end else if (pix_step) begin
      up_sr <= {up_sr[2:0], pix_up};
      lo_sr <= {lo_sr[2:0], pix_lo};
    end
  end

  // Shift clock divider, runs only inside the shift-clock window
  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sc_cnt <= 5'h00;
    end else if (!shift_win || sc_cnt >= sc_div - 5'h01) begin
      sc_cnt <= 5'h00;
    end else begin
      sc_cnt <= sc_cnt + 5'h01;
    end
  end

  // Panel outputs; held low in CRT mode
  always_ff @(posedge DOT_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LCD_SHIFT_CLOCK <= 1'b0;
      LCD_UPPER_DATA  <= 4'h0;
      LCD_LOWER_DATA  <= 4'h0;
    end else if (!lcd) begin
      LCD_SHIFT_CLOCK <= 1'b0;
      LCD_UPPER_DATA  <= 4'h0;
      LCD_LOWER_DATA  <= 4'h0;
    end else begin
      LCD_SHIFT_CLOCK <= shift_win && (sc_cnt >= (sc_div >> 1));
      if (shift_win && sc_cnt == 5'h00) begin
        LCD_UPPER_DATA <= up_sr & lane_mask;
        LCD_LOWER_DATA <= two_screen ? (lo_sr & lane_mask) : 4'h0;
      end
    end
  end

endmodule : dsa_top
`default_nettype wire
